/* File: core/axis_flag_bank.sv */
`timescale 1ns/1ns
`include "event_router_defines.svh"

// Sticky per-axis flags; a clear held high keeps the flag at zero
module axis_flag_bank (
  input wire logic ref_clk,
  input wire logic sys_rst,
  axis_flag_if.bank port
);

  // Each flag latches its event and drops only under its clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port.flags <= '0;
    end else begin
      // Held clear blocks new sets so software must release it to re-arm
      port.flags <= (port.flags | port.set_req) & ~port.clear_req;
    end
  end

endmodule

/* File: core/axis_flag_if.sv */
`timescale 1ns/1ns
`include "event_router_defines.svh"

// Set, clear and read-back of the per-axis detection flags
interface axis_flag_if;
  logic [`AXIS_FLAG_COUNT-1:0] set_req;
  logic [`AXIS_FLAG_COUNT-1:0] clear_req;
  logic [`AXIS_FLAG_COUNT-1:0] flags;

  modport router (output set_req, output clear_req, input flags);
  modport bank (input set_req, input clear_req, output flags);
endinterface

/* File: core/event_router_defines.svh */
`ifndef EVENT_ROUTER_DEFINES_SVH
`define EVENT_ROUTER_DEFINES_SVH

// Register offsets on the register port
`define OFS_DETECTION_SOURCE_STATUS 8'h0A
`define OFS_INTERRUPT_LATCH_RESET 8'h17
`define OFS_CONTROL_ONE 8'h18
`define OFS_SECOND_PULSE_WINDOW 8'h1E

// Reset values
`define RST_INTERRUPT_LATCH_RESET 8'h00
`define RST_CONTROL_ONE 8'h00
`define RST_SECOND_PULSE_WINDOW 8'h00
`define RST_READ_DATA 8'h00

// Control one field positions
`define CTL_PIN_SWAP_BIT 0
`define CTL_ROUTE_LSB 1
`define CTL_ROUTE_MSB 2

// Latch reset field positions
`define LRS_FIRST_CLEAR_BIT 0
`define LRS_SECOND_CLEAR_BIT 1

// Detection source field positions
`define DSS_FIRST_STATUS_BIT 0
`define DSS_SECOND_STATUS_BIT 1
`define DSS_PULSE_Z_BIT 2
`define DSS_PULSE_X_BIT 4
`define DSS_LEVEL_Z_BIT 5
`define DSS_LEVEL_X_BIT 7

// Number of per-axis flags held in the latch bank
`define AXIS_FLAG_COUNT 6

`endif

/* File: core/event_router_pkg.sv */
package event_router_pkg;

  // Event class routing held in the route select field
  typedef enum logic [1:0] {
    ROUTE_LEVEL_PULSE = 2'b00,
    ROUTE_PULSE_LEVEL = 2'b01,
    ROUTE_SINGLE_DOUBLE = 2'b10,
    ROUTE_RESERVED = 2'b11
  } route_mode_t;

  // Which event classes feed one status bit
  typedef struct packed {
    logic level;
    logic single;
    logic double;
  } event_source_t;

endpackage

/* File: core/motion_event_interrupt_router.sv */
`timescale 1ns/1ns
`include "event_router_defines.svh"

module motion_event_interrupt_router
  import event_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] level_hit,
  input wire logic [2:0] first_pulse_hit,
  input wire logic double_pulse_hit,
  input wire logic [7:0] latency_window_value,
  output logic first_interrupt,
  output logic second_interrupt,
  output logic pulse_restart,
  output logic [7:0] control_one,
  output logic [7:0] second_pulse_window
);

  // Software-written clear controls
  logic [7:0] interrupt_latch_reset;
  // Latched interrupt status bits
  logic first_status;
  logic second_status;
  // Combined next values of the status bits
  logic next_first_status;
  logic next_second_status;
  // Decoded route and event classes
  route_mode_t route_mode;
  logic level_event;
  logic single_event;
  logic double_event;
  logic window_zero;
  logic latency_zero;
  event_source_t first_source;
  event_source_t second_source;
  // Effective clears after mode-dependent gating
  logic first_latch_clear;
  logic second_latch_clear;
  logic clear_first_status;
  logic clear_second_status;
  logic clear_level_flags;
  logic clear_pulse_flags;
  // Register port decode
  logic wr_latch_reset;
  logic wr_control_one;
  logic wr_second_window;

  axis_flag_if flag_port ();

  // Event classes to which one status bit listens in a given mode
  function automatic event_source_t route_source(
    input route_mode_t mode,
    input logic second,
    input logic tw_zero,
    input logic lt_zero
  );
    event_source_t src;
    src = '{level: 1'b0, single: 1'b0, double: 1'b0};
    unique case (mode)
      ROUTE_LEVEL_PULSE: begin
        // First takes level, second takes any pulse
        src.level = !second;
        src.single = second;
        src.double = second;
      end
      ROUTE_PULSE_LEVEL: begin
        // The reverse mapping
        src.level = second;
        src.single = !second;
        src.double = !second;
      end
      ROUTE_SINGLE_DOUBLE: begin
        if (!second) begin
          src.single = 1'b1;
        end else if (tw_zero) begin
          src.single = 1'b1;
        end else if (!lt_zero) begin
          src.double = 1'b1;
        end else begin
          // Window set without latency: accept either pulse kind
          src.single = 1'b1;
          src.double = 1'b1;
        end
      end
      ROUTE_RESERVED: begin
        // Reserved code routes nothing
        src.level = 1'b0;
      end
    endcase
    return src;
  endfunction

  // Does this status bit see an event this cycle
  function automatic logic source_hit(
    input event_source_t src,
    input logic lvl,
    input logic sgl,
    input logic dbl
  );
    return (src.level & lvl) | (src.single & sgl) | (src.double & dbl);
  endfunction

  // Field decode of the stored controls
  assign route_mode = route_mode_t'(control_one[`CTL_ROUTE_MSB:`CTL_ROUTE_LSB]);
  assign first_latch_clear = interrupt_latch_reset[`LRS_FIRST_CLEAR_BIT];
  assign second_latch_clear = interrupt_latch_reset[`LRS_SECOND_CLEAR_BIT];

  // Event classes from the detectors
  assign level_event = |level_hit;
  assign single_event = |first_pulse_hit;
  assign double_event = double_pulse_hit;
  assign window_zero = (second_pulse_window == 8'h00);
  assign latency_zero = (latency_window_value == 8'h00);

  // Route selection for each status bit
  assign first_source = route_source(route_mode, 1'b0, window_zero, latency_zero);
  assign second_source = route_source(route_mode, 1'b1, window_zero, latency_zero);

  // Register port write strobes
  assign wr_latch_reset = reg_wr_en && (reg_addr == `OFS_INTERRUPT_LATCH_RESET);
  assign wr_control_one = reg_wr_en && (reg_addr == `OFS_CONTROL_ONE);
  assign wr_second_window = reg_wr_en && (reg_addr == `OFS_SECOND_PULSE_WINDOW);

  // Which clear acts on which status bit, by mode
  always_comb begin
    clear_first_status = first_latch_clear;
    clear_second_status = second_latch_clear;
    clear_level_flags = 1'b0;
    clear_pulse_flags = 1'b0;
    unique case (route_mode)
      ROUTE_LEVEL_PULSE: begin
        clear_level_flags = first_latch_clear;
        clear_pulse_flags = second_latch_clear;
      end
      ROUTE_PULSE_LEVEL: begin
        clear_level_flags = second_latch_clear;
        clear_pulse_flags = first_latch_clear;
      end
      ROUTE_SINGLE_DOUBLE: begin
        // Only the second clear reaches the first status here
        clear_first_status = second_latch_clear;
        clear_level_flags = first_latch_clear | second_latch_clear;
        clear_pulse_flags = second_latch_clear;
      end
      ROUTE_RESERVED: begin
        clear_level_flags = first_latch_clear | second_latch_clear;
        clear_pulse_flags = first_latch_clear | second_latch_clear;
      end
    endcase
  end

  // Sticky status with a held clear that blocks re-triggering
  always_comb begin
    next_first_status = first_status |
      source_hit(first_source, level_event, single_event, double_event);
    next_second_status = second_status |
      source_hit(second_source, level_event, single_event, double_event);
    if (clear_first_status) begin
      next_first_status = 1'b0;
    end
    if (clear_second_status) begin
      next_second_status = 1'b0;
    end
  end

  // Status latches hold after the event ends
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_status <= 1'b0;
      second_status <= 1'b0;
    end else begin
      first_status <= next_first_status;
      second_status <= next_second_status;
    end
  end

  // Pins follow the same next values so on every edge they match the status bits, straight or crossed by the swap bit
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_interrupt <= 1'b0;
      second_interrupt <= 1'b0;
    end else if (control_one[`CTL_PIN_SWAP_BIT]) begin
      // Crossed wiring
      first_interrupt <= next_second_status;
      second_interrupt <= next_first_status;
    end else begin
      // Straight wiring
      first_interrupt <= next_first_status;
      second_interrupt <= next_second_status;
    end
  end

  // Per-axis flag bank set and clear
  assign flag_port.set_req = {level_hit, first_pulse_hit};
  assign flag_port.clear_req = {{3{clear_level_flags}}, {3{clear_pulse_flags}}};

  axis_flag_bank flag_bank (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .port(flag_port.bank)
  );

  // Latch reset register; bits above the two clears read as written
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_latch_reset <= `RST_INTERRUPT_LATCH_RESET;
    end else if (wr_latch_reset) begin
      interrupt_latch_reset <= reg_wdata;
    end
  end

  // Restart pulse for the pulse detector on a rising second clear in mode 10
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_restart <= 1'b0;
    end else begin
      pulse_restart <= wr_latch_reset && reg_wdata[`LRS_SECOND_CLEAR_BIT] &&
        !second_latch_clear && (route_mode == ROUTE_SINGLE_DOUBLE);
    end
  end

  // Control one register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_one <= `RST_CONTROL_ONE;
    end else if (wr_control_one) begin
      control_one <= reg_wdata;
    end
  end

  // Second pulse window register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      second_pulse_window <= `RST_SECOND_PULSE_WINDOW;
    end else if (wr_second_window) begin
      second_pulse_window <= reg_wdata;
    end
  end

  // Registered read data; unmapped addresses return zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `RST_READ_DATA;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        `OFS_DETECTION_SOURCE_STATUS: begin
          // Level flags high, pulse flags next, statuses lowest
          reg_rdata <= {flag_port.flags, second_status, first_status};
        end
        `OFS_INTERRUPT_LATCH_RESET: begin
          reg_rdata <= interrupt_latch_reset;
        end
        `OFS_CONTROL_ONE: begin
          reg_rdata <= control_one;
        end
        `OFS_SECOND_PULSE_WINDOW: begin
          reg_rdata <= second_pulse_window;
        end
        default: begin
          reg_rdata <= `RST_READ_DATA;
        end
      endcase
    end
  end

endmodule

/* File: testbench/motion_event_interrupt_router_properties.sv */
`timescale 1ns/1ns
// Watches the router ports; mirrors the clear bits from register writes
module motion_event_interrupt_router_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] level_hit,
  input wire logic [2:0] first_pulse_hit,
  input wire logic double_pulse_hit,
  input wire logic [7:0] latency_window_value,
  input wire logic first_interrupt,
  input wire logic second_interrupt,
  input wire logic pulse_restart,
  input wire logic [7:0] control_one,
  input wire logic [7:0] second_pulse_window
);
  logic [1:0] clr; // Clear bits as the latch reset register holds them
  logic [1:0] mode; // Route select field
  logic wr17; // Write to the latch reset register
  assign mode = control_one[2:1];
  assign wr17 = reg_wr_en && reg_addr == 8'h17;
  // Mirror updates on the same edge as the register itself
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr <= 2'b00;
    end else if (wr17) begin
      clr <= reg_wdata[1:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_level_first: assert property (
    mode == 2'b00 && !control_one[0] && |level_hit && !clr[0] |=> first_interrupt)
    else $error("level event missed on first pin");
  chk_pulse_second: assert property (
    mode == 2'b00 && !control_one[0] && |first_pulse_hit && !clr[1] |=> second_interrupt)
    else $error("pulse event missed on second pin");
  chk_swap_cross: assert property (
    mode == 2'b01 && control_one[0] && |level_hit && !clr[1] |=> first_interrupt)
    else $error("crossed pin did not follow second status");
  chk_status_sticky: assert property (
    first_interrupt && clr == 2'b00 && !reg_wr_en |=> first_interrupt)
    else $error("first pin dropped without a clear");
  chk_mode10_first_clear: assert property (
    mode == 2'b10 && clr == 2'b01 && first_interrupt && !control_one[0] && !reg_wr_en
    |=> first_interrupt)
    else $error("first clear acted in mode 10");
  chk_mode10_clear_both: assert property (
    mode == 2'b10 && clr[1] |=> !first_interrupt && !second_interrupt)
    else $error("second clear left a status set in mode 10");
  chk_restart_pulse: assert property (
    wr17 && reg_wdata[1] && !clr[1] && mode == 2'b10 |=> pulse_restart)
    else $error("pulse restart missing after second clear");
  chk_source_status: assert property (
    reg_rd_en && reg_addr == 8'h0A && !control_one[0]
    |=> reg_rdata[1:0] == $past({second_interrupt, first_interrupt}))
    else $error("status bits in source read differ from pins");
  cover property (pulse_restart);
  cover property (first_interrupt && second_interrupt);
  cover property (control_one[0] && first_interrupt);
endmodule

/* File: testbench/test_motion_event_interrupt_router.sv */
`timescale 1ns/1ns
`define CHK(n, e, a) checks++; if ((a) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, a); miscompares++; end
module test_motion_event_interrupt_router;
  logic ref_clk, sys_rst, reg_wr_en, reg_rd_en, double_pulse_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, latency_window_value;
  logic [7:0] control_one, second_pulse_window;
  logic [2:0] level_hit, first_pulse_hit;
  logic first_interrupt, second_interrupt, pulse_restart;
  int checks = 0;
  int miscompares = 0;
  int restarts = 0; // Restart pulses seen
  motion_event_interrupt_router dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .level_hit(level_hit),
    .first_pulse_hit(first_pulse_hit), .double_pulse_hit(double_pulse_hit),
    .latency_window_value(latency_window_value), .first_interrupt(first_interrupt),
    .second_interrupt(second_interrupt), .pulse_restart(pulse_restart),
    .control_one(control_one), .second_pulse_window(second_pulse_window));
  // 100 ns period clock
  always #50 ref_clk = ~ref_clk;
  // Count restarts; one-cycle pulse so each edge counts once
  always @(posedge ref_clk) begin
    if (pulse_restart === 1'b1) begin
      restarts++;
    end
  end
  // All tasks start and end just after a rising edge
  // Each access leaves one idle edge behind it, so that no strobe is re-driven in one time step
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick();
    reg_wr_en = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick();
    reg_rd_en = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
    tick();
  endtask
  // One-cycle event pulse on the detector inputs
  task automatic ev(input logic [2:0] l, input logic [2:0] p, input logic d);
    level_hit = l;
    first_pulse_hit = p;
    double_pulse_hit = d;
    tick();
    level_hit = 3'b000;
    first_pulse_hit = 3'b000;
    double_pulse_hit = 1'b0;
    tick();
  endtask
  task automatic pins(input logic e1, input logic e2);
    `CHK("first_interrupt", e1, first_interrupt)
    `CHK("second_interrupt", e2, second_interrupt)
  endtask
  // Clear both latches, then re-arm by writing zero
  task automatic clear();
    wr(8'h17, 8'h03);
    tick();
    pins(1'b0, 1'b0);
    wr(8'h17, 8'h00);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = '0;
    {level_hit, first_pulse_hit, double_pulse_hit} = '0;
    latency_window_value = 8'h05;
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    rd(8'h0A, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h1E, 8'h00);
    wr(8'h1E, 8'hA5);
    `CHK("second_pulse_window", 8'hA5, second_pulse_window)
    rd(8'h1E, 8'hA5);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    rd(8'h33, 8'h00);
    ev(3'b100, 3'b000, 1'b0);
    pins(1'b1, 1'b0);
    repeat (4) tick();
    pins(1'b1, 1'b0);
    ev(3'b000, 3'b010, 1'b0);
    rd(8'h0A, 8'h8B);
    wr(8'h17, 8'h01);
    tick();
    pins(1'b0, 1'b1);
    wr(8'h17, 8'h00);
    clear();
    rd(8'h0A, 8'h00);
    // Mode 01: classes swap between the status bits
    wr(8'h18, 8'h02);
    ev(3'b001, 3'b000, 1'b0);
    pins(1'b0, 1'b1);
    ev(3'b000, 3'b001, 1'b0);
    pins(1'b1, 1'b1);
    clear();
    wr(8'h18, 8'h03);
    ev(3'b001, 3'b000, 1'b0);
    pins(1'b1, 1'b0);
    clear();
    // Mode 10 with zero window: single pulse on both
    wr(8'h18, 8'h04);
    `CHK("control_one", 8'h04, control_one)
    wr(8'h1E, 8'h00);
    ev(3'b000, 3'b001, 1'b0);
    pins(1'b1, 1'b1);
    wr(8'h17, 8'h01);
    tick();
    pins(1'b1, 1'b1);
    wr(8'h17, 8'h00);
    rd(8'h0A, 8'h07);
    wr(8'h17, 8'h02);
    tick();
    pins(1'b0, 1'b0);
    rd(8'h0A, 8'h00);
    tick();
    `CHK("restarts", 1, restarts)
    wr(8'h17, 8'h00);
    // Nonzero window and latency: second waits for a double pulse
    wr(8'h1E, 8'h10);
    ev(3'b000, 3'b001, 1'b0);
    pins(1'b1, 1'b0);
    ev(3'b000, 3'b000, 1'b1);
    pins(1'b1, 1'b1);
    // Window set, latency zero: second takes a single pulse as well
    clear();
    latency_window_value = 8'h00;
    ev(3'b000, 3'b100, 1'b0);
    pins(1'b1, 1'b1);
    // Reserved route code: flags still latch, no status is set
    clear();
    wr(8'h18, 8'h06);
    ev(3'b111, 3'b111, 1'b1);
    pins(1'b0, 1'b0);
    rd(8'h0A, 8'hFC);
    // Mid-run reset returns control one, the window, read data and the restart pin to their defaults
    sys_rst = 1'b1;
    tick();
    `CHK("control_one", 8'h00, control_one)
    `CHK("second_pulse_window", 8'h00, second_pulse_window)
    `CHK("reg_rdata", 8'h00, reg_rdata)
    `CHK("pulse_restart", 1'b0, pulse_restart)
    sys_rst = 1'b0;
    rd(8'h1E, 8'h00);
    rd(8'h0A, 8'h00);
    results();
  end
endmodule
bind motion_event_interrupt_router motion_event_interrupt_router_properties chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .level_hit(level_hit), .first_pulse_hit(first_pulse_hit),
  .double_pulse_hit(double_pulse_hit), .latency_window_value(latency_window_value),
  .first_interrupt(first_interrupt), .second_interrupt(second_interrupt),
  .pulse_restart(pulse_restart), .control_one(control_one),
  .second_pulse_window(second_pulse_window));
